// >>> inc/data_move_pkg.sv
// Shared constants and types of the data-move execution block
package data_move_pkg;

   // Instruction word layout
   localparam int unsigned IW_W = 16;              // Program word width
   localparam int unsigned DA_W = 12;              // Data-space address width
   localparam int unsigned BY_W = 8;               // Data byte width

   // Opcode patterns (upper bits of the word)
   localparam logic [5:0] OPC_PLOAD_HI  = 6'h38;   // 1110 00 : pointer load, word 1
   localparam logic [7:0] OPC_PLOAD_LO  = 8'hf0;   // 1111 0000 : pointer load, word 2
   localparam logic [5:0] OPC_MOVE_FILE = 6'h14;   // 0101 00 : move file
   localparam logic [3:0] OPC_MEM_SRC   = 4'hc;    // 1100 : mem-to-mem, word 1
   localparam logic [3:0] OPC_MEM_DST   = 4'hf;    // 1111 : continuation word
   localparam logic [7:0] OPC_BANK_LOAD = 8'h01;   // 0000 0001 : bank select load

   // Field positions
   localparam int unsigned BIT_D = 9;              // Destination bit
   localparam int unsigned BIT_A = 8;              // Access bit
   localparam int unsigned PTR_POS = 8;            // Pointer index, two bits from here

   // Addressing constants
   localparam logic [7:0] IDX_LIMIT   = 8'h5f;     // Indexed offset upper bound
   localparam logic [7:0] ACC_SPLIT   = 8'h60;     // Access bank: low part below this
   localparam logic [3:0] SFR_BANK    = 4'hf;      // Bank of upper access part
   localparam logic [1:0] PTR_COUNT   = 2'h3;      // Pointer indexes 0..2 legal
   localparam logic [3:0] BANK_HI_ZERO = 4'h0;     // Forced upper bank-select nibble

   // Reset values
   localparam logic [7:0] RST_BYTE = 8'h00;        // Registers reset to zero

   // Quarter-cycle phases
   typedef enum logic [1:0] {
      Q1 = 2'b00,
      Q2 = 2'b01,
      Q3 = 2'b10,
      Q4 = 2'b11
   } quarter_t;

   // Data memory request carried to the data space
   typedef struct packed {
      logic            rd;                         // Read strobe
      logic            wr;                         // Write strobe
      logic [DA_W-1:0] addr;                       // Full address
      logic [BY_W-1:0] wdata;                      // Write data
   } mem_req_t;

   // Status flags touched by this block
   typedef struct packed {
      logic n;                                     // Negative
      logic z;                                     // Zero
   } flags_t;

endpackage

// >>> rtl/quarter_gen.sv
// Quarter-cycle phase generator
`timescale 1ns/1ps
module quarter_gen
   import data_move_pkg::*;
(
   // Clock and reset
   input  wire logic     clk,
   input  wire logic     sys_rst,
   // Phase outputs
   output quarter_t      phase,
   output logic          cyc_end
);

   quarter_t phase_ff;                             // Current quarter

   // Steps Q1..Q4 and wraps
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         phase_ff <= Q1;
      end else begin
         phase_ff <= quarter_t'(phase_ff + 2'd1);
      end
   end

   assign phase   = phase_ff;
   assign cyc_end = (phase_ff == Q4);              // Last quarter of a cycle

endmodule

// >>> rtl/addr_resolver.sv
// Byte-operand address resolution: access bank, banked, indexed offset
`timescale 1ns/1ps
module addr_resolver
   import data_move_pkg::*;
(
   // Operand fields
   input  wire logic [7:0]      f_addr,
   input  wire logic            acc_bit,
   // Core state
   input  wire logic [3:0]      bank_sel,
   input  wire logic            ext_en,
   input  wire logic [DA_W-1:0] ptr2,
   // Resolved address
   output logic [DA_W-1:0]      full_addr,
   output logic                 indexed
);

   logic [DA_W-1:0] acc_addr;                      // Access-bank address
   logic [DA_W-1:0] bank_addr;                     // Banked address
   logic [DA_W-1:0] idx_addr;                      // Pointer plus offset

   // Access bank: low part in bank 0, upper part in the top bank
   assign acc_addr  = (f_addr < ACC_SPLIT) ? {4'h0, f_addr} : {SFR_BANK, f_addr};
   assign bank_addr = {bank_sel, f_addr};
   assign idx_addr  = DA_W'(ptr2 + {4'h0, f_addr});
   assign indexed   = ext_en && !acc_bit && (f_addr <= IDX_LIMIT);
   assign full_addr = indexed ? idx_addr : (acc_bit ? bank_addr : acc_addr);

endmodule

// >>> rtl/data_move_exec.sv
// Decode and execute of the four data-move instructions
// How it works
// - Pointer load writes 12-bit literal, flags kept
// - Pointer load words: 111000ff kkkk, 11110000 kkkkkkkk
// - Pointer high nibble cycle one, low byte cycle two
// - Move file to W or itself, N Z
// - Access bit 0 access bank, 1 banked
// - Extended set, a=0, f<=5Fh: indexed offset
// - Move file: full bank, one cycle, Q2/Q4
// - Mem-to-mem move: 12-bit addresses, flags kept
// - Mem-to-mem move may use W either end
// - Mem-to-mem: read cycle one, write Q4 two
// - Bank select load keeps upper nibble zero
`timescale 1ns/1ps
module data_move_exec
   import data_move_pkg::*;
(
   // Clock and reset
   input  wire logic            clk,
   input  wire logic            sys_rst,
   // Instruction stream
   input  wire logic [IW_W-1:0] instr,
   input  wire logic            instr_valid,
   input  wire logic            ext_en,
   // Data space
   output mem_req_t             mem_req,
   input  wire logic [BY_W-1:0] mem_rdata,
   // Core registers
   input  wire logic [BY_W-1:0] w_in,
   input  wire logic [DA_W-1:0] w_addr,
   output logic [BY_W-1:0]      w_out,
   output logic                 w_wr,
   output flags_t               flags,
   output logic                 flags_wr,
   output logic [BY_W-1:0]      bank_select,
   output logic [DA_W-1:0]      ptr0,
   output logic [DA_W-1:0]      ptr1,
   output logic [DA_W-1:0]      ptr2,
   // Status
   output logic                 busy,
   output logic                 illegal
);

   quarter_t phase;                                // Current quarter
   logic     cyc_end;                              // Q4 marker

   quarter_gen u_qgen (
      .clk     (clk),
      .sys_rst (sys_rst),
      .phase   (phase),
      .cyc_end (cyc_end)
   );

   // Decoder states
   typedef enum logic [1:0] {
      S_FETCH    = 2'b00,                          // Expecting a first word
      S_PLOAD_LO = 2'b01,                          // Expecting pointer low word
      S_MEM_DST  = 2'b10                           // Expecting destination word
   } dstate_t;

   dstate_t         state_ff, nxt_state;           // Which word is expected
   logic [IW_W-1:0] ir_ff;                         // Instruction latched at Q1
   logic [1:0]      psel_ff;                       // Selected pointer
   logic [BY_W-1:0] data_ff;                       // Byte read in Q2
   logic [DA_W-1:0] src_ff;                        // Mem-to-mem source
   logic [BY_W-1:0] bank_sel_ff;                   // Bank select register
   logic [DA_W-1:0] ptr_ff [3];                    // Pointer pairs
   logic            ir_vld_ff;                     // Latched word is valid
   logic            ill_ff;                        // Illegal decode seen

   // Slot qualifiers: each word is decoded only in its own slot
   wire       in_fetch = ir_vld_ff && (state_ff == S_FETCH);
   wire       in_plo   = ir_vld_ff && (state_ff == S_PLOAD_LO);
   wire       in_mdst  = ir_vld_ff && (state_ff == S_MEM_DST);
   // Pointer index sits in the two bits just below the opcode
   wire [1:0] ptr_idx  = ir_ff[PTR_POS +: 2];

   // Decode of the latched word
   wire is_pload_hi  = in_fetch && (ir_ff[15:10] == OPC_PLOAD_HI);
   wire is_move_file = in_fetch && (ir_ff[15:10] == OPC_MOVE_FILE);
   wire is_mem_src   = in_fetch && (ir_ff[15:12] == OPC_MEM_SRC);
   wire is_bank_load = in_fetch && (ir_ff[15:8] == OPC_BANK_LOAD);
   wire is_pload_lo  = in_plo && (ir_ff[15:8] == OPC_PLOAD_LO);
   wire is_mem_dst   = in_mdst && (ir_ff[15:12] == OPC_MEM_DST);
   // A word out of place in a continuation slot is dropped, never run
   wire bad_cont = ir_vld_ff && (state_ff != S_FETCH) && !is_pload_lo && !is_mem_dst;
   // Only three pointers exist; the fourth index is refused
   wire bad_ptr  = is_pload_hi && (ptr_idx == PTR_COUNT);

   // Byte operand address of the move-file word
   logic [DA_W-1:0] file_addr;                     // Resolved operand address
   logic            file_idx;                      // Indexed offset in use

   addr_resolver u_addr (
      .f_addr    (ir_ff[7:0]),
      .acc_bit   (ir_ff[BIT_A]),
      .bank_sel  (bank_sel_ff[3:0]),
      .ext_en    (ext_en),
      .ptr2      (ptr_ff[2]),
      .full_addr (file_addr),
      .indexed   (file_idx)
   );

   // Mem-to-mem ends: an end at w_addr takes W through w_in or w_out, not the data space
   wire [DA_W-1:0] mm_src   = ir_ff[11:0];
   wire [DA_W-1:0] mm_dst   = ir_ff[11:0];
   wire            src_is_w = src_ff == w_addr;
   wire [BY_W-1:0] mm_byte  = src_is_w ? w_in : data_ff;
   wire            dst_is_w = mm_dst == w_addr;

   // Memory strobes per quarter
   wire rd_q2   = (phase == Q2) && (is_move_file || is_mem_src);
   wire wr_file = (phase == Q4) && is_move_file && ir_ff[BIT_D];
   wire wr_mem  = (phase == Q4) && is_mem_dst && !dst_is_w;
   // Read address: source word or resolved byte operand
   wire [DA_W-1:0] rd_addr = is_mem_src ? mm_src : file_addr;

   // Data-space request, combinational from the quarter and decode
   assign mem_req.rd    = rd_q2;
   assign mem_req.wr    = wr_file || wr_mem;
   assign mem_req.addr  = rd_q2 ? rd_addr : (wr_mem ? mm_dst : file_addr);
   assign mem_req.wdata = wr_mem ? mm_byte : data_ff;

   // W and flag writes at Q4
   wire file_to_w = (phase == Q4) && is_move_file && !ir_ff[BIT_D];
   wire mm_to_w   = (phase == Q4) && is_mem_dst && dst_is_w;
   assign w_wr     = file_to_w || mm_to_w;
   assign w_out    = file_to_w ? data_ff : mm_byte;
   assign flags_wr = (phase == Q4) && is_move_file;       // Only move file
   assign flags.n  = data_ff[BY_W-1];
   assign flags.z  = (data_ff == RST_BYTE);

   // Next decoder state taken at the end of each cycle
   always_comb begin
      nxt_state = state_ff;
      if (cyc_end && ir_vld_ff) begin
         unique case (state_ff)
            S_FETCH: begin
               if (is_pload_hi && !bad_ptr) begin
                  nxt_state = S_PLOAD_LO;
               end else if (is_mem_src) begin
                  nxt_state = S_MEM_DST;
               end else begin
                  nxt_state = S_FETCH;                        // One-word instruction
               end
            end
            S_PLOAD_LO: nxt_state = S_FETCH;
            S_MEM_DST:  nxt_state = S_FETCH;
            default:    nxt_state = S_FETCH;                  // Unused code recovers
         endcase
      end
   end

   // Instruction latch at Q1
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ir_ff     <= '0;
         ir_vld_ff <= 1'b0;
      end else if (phase == Q1) begin
         ir_ff     <= instr;
         ir_vld_ff <= instr_valid;
      end
   end

   // Decoder state
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_ff <= S_FETCH;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Q2 read capture and source latch
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         data_ff <= RST_BYTE;
         src_ff  <= '0;
      end else if (rd_q2) begin
         data_ff <= mem_rdata;
         if (is_mem_src) begin
            src_ff <= mm_src;
         end
      end
   end

   // Pointer index held across the two words
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         psel_ff <= 2'h0;
      end else if (is_pload_hi && cyc_end) begin
         psel_ff <= ptr_idx;
      end
   end

   // Pointer pairs: upper nibble in cycle one, low byte in cycle two
   for (genvar p = 0; p < 3; p++) begin : g_ptr
      wire hi_wr = cyc_end && is_pload_hi && !bad_ptr && (ptr_idx == 2'(p));
      wire lo_wr = cyc_end && is_pload_lo && (psel_ff == 2'(p));
      always_ff @(posedge clk or posedge sys_rst) begin
         if (sys_rst) begin
            ptr_ff[p] <= '0;
         end else if (hi_wr) begin
            ptr_ff[p][11:8] <= ir_ff[3:0];
         end else if (lo_wr) begin
            ptr_ff[p][7:0] <= ir_ff[7:0];
         end
      end
   end

   // Bank select load, upper nibble held at zero
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         bank_sel_ff <= RST_BYTE;
      end else if (cyc_end && is_bank_load) begin
         bank_sel_ff <= {BANK_HI_ZERO, ir_ff[3:0]};
      end
   end

   // Illegal decode flag, sticky until reset
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ill_ff <= 1'b0;
      end else if (cyc_end && (bad_cont || bad_ptr)) begin
         ill_ff <= 1'b1;
      end
   end

   // Register outputs
   assign bank_select = bank_sel_ff;
   assign ptr0        = ptr_ff[0];
   assign ptr1        = ptr_ff[1];
   assign ptr2        = ptr_ff[2];
   assign busy        = state_ff != S_FETCH;
   assign illegal     = ill_ff;

   // Indexed flag reserved for the offset adder path
   wire unused_idx = file_idx;

endmodule

// >>> bench/data_move_exec_properties.sv
// Port-level timing checks for the data-move execution block
`timescale 1ns/1ps
module data_move_exec_properties
   import data_move_pkg::*;
(
   // Clock and reset
   input wire logic            clk,
   input wire logic            sys_rst,
   // Observed outputs
   input wire mem_req_t        mem_req,
   input wire logic [BY_W-1:0] w_out,
   input wire logic            w_wr,
   input wire flags_t          flags,
   input wire logic            flags_wr,
   input wire logic [BY_W-1:0] bank_select,
   input wire logic [DA_W-1:0] ptr0,
   input wire logic            busy,
   input wire logic            illegal
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Read strobe of the same instruction cycle
   sequence s_rd_q2;
      $past(mem_req.rd, 2);
   endsequence
   // Read strobe of the previous instruction cycle
   sequence s_rd_prev;
      $past(mem_req.rd, 6);
   endsequence
   property p_flag_rd; flags_wr |-> s_rd_q2; endproperty
   property p_wb_addr;
      flags_wr && mem_req.wr |-> mem_req.addr == $past(mem_req.addr, 2);
   endproperty
   property p_z; flags_wr |-> flags.z == ((w_wr ? w_out : mem_req.wdata) == 8'h00); endproperty
   property p_n; flags_wr |-> flags.n == (w_wr ? w_out[7] : mem_req.wdata[7]); endproperty
   property p_mm_wr; mem_req.wr && !flags_wr |-> s_rd_prev; endproperty
   property p_one_rd; mem_req.rd |=> !mem_req.rd [*3]; endproperty
   property p_bank_hi; bank_select[7:4] == 4'h0; endproperty
   property p_sticky; illegal |=> illegal; endproperty
   property p_ptr; $changed(ptr0) |-> !flags_wr && !mem_req.wr; endproperty
   property p_busy; busy |-> !flags_wr; endproperty
   a_flag_rd: assert property (p_flag_rd) else $error("flags without read");
   a_wb_addr: assert property (p_wb_addr) else $error("write-back address");
   a_z: assert property (p_z) else $error("zero flag");
   a_n: assert property (p_n) else $error("negative flag");
   a_mm_wr: assert property (p_mm_wr) else $error("move write timing");
   a_one_rd: assert property (p_one_rd) else $error("extra read");
   a_bank_hi: assert property (p_bank_hi) else $error("bank select upper nibble");
   a_sticky: assert property (p_sticky) else $error("illegal dropped");
   a_ptr: assert property (p_ptr) else $error("pointer with flags");
   a_busy: assert property (p_busy) else $error("flags in second word");
endmodule

bind data_move_exec data_move_exec_properties i_props (
   .clk(clk), .sys_rst(sys_rst), .mem_req(mem_req), .w_out(w_out), .w_wr(w_wr),
   .flags(flags), .flags_wr(flags_wr), .bank_select(bank_select), .ptr0(ptr0),
   .busy(busy), .illegal(illegal));

// >>> bench/data_move_exec_tb.sv
// Self-checking bench for the data-move execution block
`timescale 1ns/1ps
module data_move_exec_tb
   import data_move_pkg::*;
;
   logic            clk, sys_rst, instr_valid, ext_en, w_wr, flags_wr, busy, illegal;
   logic [IW_W-1:0] instr;
   logic [BY_W-1:0] mem_rdata, w_in, w_out, bank_select;
   logic [DA_W-1:0] w_addr, ptr0, ptr1, ptr2, lit;
   logic [DA_W-1:0] ptr_v [3];                     // Pointers by index
   mem_req_t        mem_req;
   flags_t          flags;
   logic [24:0]     notes [$];                     // Expected write notes
   logic [24:0]     exp_n, seen;
   logic [31:0]     r;
   logic [3:0]      bank_v;                        // Last loaded bank
   int              mismatches, checks_done, cycles;
   assign ptr_v[0] = ptr0;
   assign ptr_v[1] = ptr1;
   assign ptr_v[2] = ptr2;
   data_move_exec i_dut (.clk(clk), .sys_rst(sys_rst), .instr(instr), .instr_valid(instr_valid),
      .ext_en(ext_en), .mem_req(mem_req), .mem_rdata(mem_rdata), .w_in(w_in), .w_addr(w_addr),
      .w_out(w_out), .w_wr(w_wr), .flags(flags), .flags_wr(flags_wr), .bank_select(bank_select),
      .ptr0(ptr0), .ptr1(ptr1), .ptr2(ptr2), .busy(busy), .illegal(illegal));
   // Clock, 5 ns period
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Closing report
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Compare one write note
   task automatic cmp_wr(input logic [24:0] e, input logic [24:0] s);
      checks_done++;
      if (s !== e) begin
         mismatches++;
         $display("Error write: expected %h seen %h", e, s);
      end
   endtask
   // Compare a register value
   task automatic cmp_reg(input logic [11:0] e, input logic [11:0] s);
      checks_done++;
      if (s !== e) begin
         mismatches++;
         $display("Error register: expected %h seen %h", e, s);
      end
   endtask
   // One word per instruction cycle
   task automatic send_word(input logic [IW_W-1:0] word);
      instr = word;
      instr_valid = 1'b1;
      repeat (4) @(negedge clk);
   endtask
   // Move file with its expected result
   task automatic move_file(input logic d, input logic a, input logic [7:0] f,
                            input logic [7:0] rv, input logic [DA_W-1:0] ea);
      mem_rdata = rv;
      notes.push_back({d, ~d, 1'b1, d ? ea : 12'h000, rv, rv[7], rv == 8'h00});
      send_word({OPC_MOVE_FILE, d, a, f});
   endtask
   // Memory-to-memory move with its expected result
   task automatic move_mem(input logic [DA_W-1:0] src, input logic [DA_W-1:0] dst);
      logic [7:0] dat;
      mem_rdata = 8'($urandom);
      dat = (src == w_addr) ? w_in : mem_rdata;
      if (dst == w_addr) notes.push_back({3'b010, 12'h000, dat, 2'b00});
      else notes.push_back({3'b100, dst, dat, 2'b00});
      send_word({OPC_MEM_SRC, src});
      send_word({OPC_MEM_DST, dst});
   endtask
   // Watcher: every write strobe takes the oldest note
   always @(posedge clk) begin
      if (!sys_rst && (mem_req.wr || w_wr || flags_wr)) begin
         seen = {mem_req.wr, w_wr, flags_wr, mem_req.wr ? mem_req.addr : 12'h000,
                 mem_req.wr ? mem_req.wdata : w_out, flags_wr ? flags : 2'b00};
         exp_n = (notes.size() > 0) ? notes.pop_front() : 25'h0;
         cmp_wr(exp_n, seen);
      end
   end
   // Hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         mismatches++;
         print_verdict();
      end
   end
   // Main sequence
   initial begin
      sys_rst = 1'b1;
      instr = 16'h0000;
      instr_valid = 1'b0;
      ext_en = 1'b0;
      mem_rdata = 8'h00;
      w_in = 8'h3c;
      w_addr = 12'hfe8;
      r = $urandom(1);
      repeat (5) @(negedge clk);
      sys_rst = 1'b0;
      repeat (3) begin
         r = $urandom;
         send_word({OPC_BANK_LOAD, r[7:0]});
         cmp_reg({8'h00, r[3:0]}, {4'h0, bank_select});
      end
      bank_v = r[3:0];
      for (int i = 0; i < 3; i++) begin
         lit = 12'($urandom);
         send_word({OPC_PLOAD_HI, 2'(i), 4'h0, lit[11:8]});
         cmp_reg({8'h00, lit[11:8]}, {8'h00, ptr_v[i][11:8]});
         cmp_reg(12'h001, {11'h0, busy});
         send_word({OPC_PLOAD_LO, lit[7:0]});
         cmp_reg(lit, ptr_v[i]);
      end
      r = $urandom;
      move_file(1'b1, 1'b1, r[7:0], r[15:8], {bank_v, r[7:0]});
      move_file(1'b1, 1'b0, 8'h20, 8'h41, 12'h020);
      move_file(1'b1, 1'b0, 8'h9c, 8'h00, 12'hf9c);
      move_file(1'b0, 1'b0, 8'h10, 8'h00, 12'h000);
      move_file(1'b0, 1'b1, 8'h11, 8'h85, 12'h000);
      ext_en = 1'b1;
      move_file(1'b1, 1'b0, 8'h5f, 8'h17, ptr2 + 12'h05f);
      move_file(1'b1, 1'b0, 8'h60, 8'h92, 12'hf60);
      move_file(1'b1, 1'b1, 8'h05, 8'h66, {bank_v, 8'h05});
      ext_en = 1'b0;
      w_in = 8'($urandom);
      // Destinations kept low, clear of the counter and stack bytes
      move_mem(12'($urandom) & 12'h7ff, 12'($urandom) & 12'h7ff);
      move_mem(w_addr, 12'h123);
      move_mem(12'h456, w_addr);
      lit = ptr2;
      move_mem(12'hfff, 12'h0a5);
      cmp_reg(lit, ptr2);
      cmp_reg(12'h000, {11'h0, illegal});
      send_word({OPC_PLOAD_HI, 2'b11, 4'h0, 4'h7});
      send_word({OPC_PLOAD_LO, 8'h12});
      cmp_reg(12'h001, {11'h0, illegal});
      cmp_reg(lit, ptr2);
      instr_valid = 1'b0;
      repeat (8) @(negedge clk);
      cmp_reg(12'h000, 12'(notes.size()));
      print_verdict();
   end
endmodule
